// >>> hw/dpsr_port.sv
// One synchronous port: input registers, address counter, latency and output enables.
`timescale 1ns/1ps
`include "dpsr_defs.svh"
module dpsr_port
    import dpsr_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Requests and latency choice.
    input wire dpsr_req_t req,
    input wire logic output_latency_select,
    // Array access.
    output logic [`DPSR_ADDR_W_BIG-1:0] mem_addr,
    output logic mem_we_hi,
    output logic mem_we_lo,
    input wire logic [`DPSR_DATA_W-1:0] mem_rdata,
    // Registered port outputs.
    output dpsr_out_t flow_out,
    output dpsr_out_t pipe_out
);
    logic [`DPSR_ADDR_W_BIG-1:0] addr_r;
    logic [`DPSR_ADDR_W_BIG-1:0] addr_nxt;
    logic sel_r;
    logic sel2_r;
    logic sel;

    assign sel = !req.chip_select_low_n && req.chip_select_high;

    // Clear beats load beats advance; clear also selects location zero now.
    always_comb begin
        if (!req.counter_clear_n) begin
            addr_nxt = `DPSR_ADDR_ZERO;
        end else if (!req.address_load_strobe_n) begin
            addr_nxt = req.addr;
        end else if (!req.counter_advance_n) begin
            addr_nxt = addr_r + `DPSR_ADDR_ONE;
        end else begin
            addr_nxt = addr_r;
        end
    end

    // All synchronous inputs are taken on the rising edge.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            addr_r <= `DPSR_ADDR_ZERO;
            sel_r <= 1'h0;
            sel2_r <= 1'h0;
        end else begin
            addr_r <= addr_nxt;
            sel_r <= sel;
            sel2_r <= sel_r;
        end
    end

    // Left-port writes land at the edge they are sampled, right-port ones at the next clock_left edge; the array sees the next address.
    assign mem_addr = addr_nxt;
    assign mem_we_hi = sel && !req.read_write && !req.upper_byte_sel_n;
    assign mem_we_lo = sel && !req.read_write && !req.lower_byte_sel_n;

    // Flow data is one edge after the access, pipelined data one edge later.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flow_out <= '0;
            pipe_out <= '0;
        end else begin
            flow_out.rdata <= mem_rdata;
            flow_out.lane_oe <= (sel && req.read_write) ?
                {!req.upper_byte_sel_n, !req.lower_byte_sel_n} : 2'h0;
            pipe_out.rdata <= flow_out.rdata;
            // The enable rides one stage behind the flow one, like the data, so a
            // deselect takes two edges to float a pipelined port.
            pipe_out.lane_oe <= flow_out.lane_oe;
        end
    end

    lat_ordering_a: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> pipe_out.rdata == $past(flow_out.rdata))
        else $error("pipelined data not one cycle behind flow data");
    clear_zero_a: assert property (@(posedge clock) disable iff (rst)
        !req.counter_clear_n |-> mem_addr == `DPSR_ADDR_ZERO)
        else $error("counter clear did not access location zero");
    load_addr_a: assert property (@(posedge clock) disable iff (rst)
        (req.counter_clear_n && !req.address_load_strobe_n) |-> mem_addr == req.addr)
        else $error("load strobe did not take the external address");
    counter_step_a: assert property (@(posedge clock) disable iff (rst)
        (req.counter_clear_n && req.address_load_strobe_n && !req.counter_advance_n)
        |-> mem_addr == addr_r + `DPSR_ADDR_ONE)
        else $error("counter did not advance by one");
    pipe_chain_a: assert property (@(posedge clock) disable iff (rst)
        (output_latency_select && pipe_out.lane_oe != 2'h0) |-> sel2_r)
        else $error("pipelined enable without a twice registered select");
endmodule

// >>> hw/dpsr_top.sv
// Two symmetric synchronous ports sharing one 18-bit static RAM array.
// How it works
// - Synchronous inputs sampled on own port clock, but all array writes on the left clock.
// - Latency select per port, low flow-through.
// - Deselect floats data after next clock edge in flow-through, after the second pipelined.
// - Load strobe low captures address every edge unless counter clear is low.
// - Byte select high floats that nine-bit lane.
// - Cross-port read valid after write-to-read delay.
// - Left and right ports alike, but both ports write the array on clock_left.
// - Pipelined data arrives one cycle after flow.
// - Counter advances when enabled and neither loading nor clearing.
// - Counter clear forces address zero immediately.
// - Pipelined chip selects double registered.
`timescale 1ns/1ps
`include "dpsr_defs.svh"
module dpsr_top
    import dpsr_pkg::*;
#(
    parameter int DEPTH = `DPSR_DEPTH_BIG
)
(
    // Clocks and reset.
    input wire logic clock_left,
    input wire logic clock_right,
    input wire logic rst,
    // Left port.
    input wire dpsr_req_t req_left,
    input wire logic output_latency_select_left,
    input wire logic output_enable_left_n,
    output logic [`DPSR_DATA_W-1:0] data_out_left,
    output logic [1:0] data_oe_left,
    // Right port.
    input wire dpsr_req_t req_right,
    input wire logic output_latency_select_right,
    input wire logic output_enable_right_n,
    output logic [`DPSR_DATA_W-1:0] data_out_right,
    output logic [1:0] data_oe_right
);
    // A smaller array simply ignores the top address bit.
    localparam int AW = (DEPTH > `DPSR_DEPTH_SMALL) ?
        `DPSR_ADDR_W_BIG : `DPSR_ADDR_W_SMALL;
    logic [`DPSR_DATA_W-1:0] mem [0:DEPTH-1];
    logic [`DPSR_ADDR_W_BIG-1:0] addr_l;
    logic [`DPSR_ADDR_W_BIG-1:0] addr_r_p;
    logic whi_l;
    logic wlo_l;
    logic whi_r;
    logic wlo_r;
    logic [`DPSR_DATA_W-1:0] rd_l;
    logic [`DPSR_DATA_W-1:0] rd_r_p;
    dpsr_out_t fl_l;
    dpsr_out_t pp_l;
    dpsr_out_t fl_r;
    dpsr_out_t pp_r;
    logic [`DPSR_DATA_W-1:0] wd_l;
    logic [`DPSR_DATA_W-1:0] wd_r;
    logic sel_left;
    logic sel_right;

    // A port is selected while its low select is low and its high select is high.
    assign sel_left = !req_left.chip_select_low_n && req_left.chip_select_high;
    assign sel_right = !req_right.chip_select_low_n && req_right.chip_select_high;

    // Each port owns one clock; a read of a cell written by the other port
    // only sees it after that write's edge, which covers the skew window.
    dpsr_port u_left (
        .clock(clock_left),
        .rst(rst),
        .req(req_left),
        .output_latency_select(output_latency_select_left),
        .mem_addr(addr_l),
        .mem_we_hi(whi_l),
        .mem_we_lo(wlo_l),
        .mem_rdata(rd_l),
        .flow_out(fl_l),
        .pipe_out(pp_l)
    );
    dpsr_port u_right (
        .clock(clock_right),
        .rst(rst),
        .req(req_right),
        .output_latency_select(output_latency_select_right),
        .mem_addr(addr_r_p),
        .mem_we_hi(whi_r),
        .mem_we_lo(wlo_r),
        .mem_rdata(rd_r_p),
        .flow_out(fl_r),
        .pipe_out(pp_r)
    );

    assign wd_l = req_left.wdata;
    assign wd_r = req_right.wdata;
    assign rd_l = mem[addr_l[AW-1:0]];
    assign rd_r_p = mem[addr_r_p[AW-1:0]];

    // Simultaneous writes to one cell from both ports leave it undefined in silicon;
    // here the left port is written first, so the right one lands last.
    always_ff @(posedge clock_left) begin
        if (whi_l) mem[addr_l[AW-1:0]][`DPSR_DATA_W-1:`DPSR_BYTE_W] <= wd_l[`DPSR_DATA_W-1:`DPSR_BYTE_W];
        if (wlo_l) mem[addr_l[AW-1:0]][`DPSR_BYTE_W-1:0] <= wd_l[`DPSR_BYTE_W-1:0];
        if (whi_r) mem[addr_r_p[AW-1:0]][`DPSR_DATA_W-1:`DPSR_BYTE_W] <= wd_r[`DPSR_DATA_W-1:`DPSR_BYTE_W];
        if (wlo_r) mem[addr_r_p[AW-1:0]][`DPSR_BYTE_W-1:0] <= wd_r[`DPSR_BYTE_W-1:0];
    end

    // Latency and output enable act without the clock, so these are
    // selected combinationally from registered stages.
    always_comb begin
        data_out_left = output_latency_select_left ? pp_l.rdata : fl_l.rdata;
        data_oe_left = output_enable_left_n ? 2'h0 :
            (output_latency_select_left ? pp_l.lane_oe : fl_l.lane_oe);
    end
    // The right port mirrors the left one and ignores the left latency choice.
    always_comb begin
        data_out_right = output_latency_select_right ? pp_r.rdata : fl_r.rdata;
        data_oe_right = output_enable_right_n ? 2'h0 :
            (output_latency_select_right ? pp_r.lane_oe : fl_r.lane_oe);
    end

    // Two deselected edges in pipelined mode must leave the pins floating.
    sequence left_pipe_off_s;
        (output_latency_select_left && !sel_left) [*2];
    endsequence
    sequence right_pipe_off_s;
        (output_latency_select_right && !sel_right) [*2];
    endsequence
    // A pipelined read followed by a deselect still drives one more cycle.
    sequence left_pipe_last_s;
        (output_latency_select_left && sel_left && req_left.read_write
            && !req_left.upper_byte_sel_n)
        ##1 (output_latency_select_left && !sel_left);
    endsequence
    // A released upper lane floats one edge later in pipelined mode.
    sequence left_pipe_upper_off_s;
        (output_latency_select_left && req_left.upper_byte_sel_n)
        ##1 output_latency_select_left;
    endsequence

    // With flow timing the pins float at the first edge after a deselect.
    deselect_float_a: assert property (@(posedge clock_left) disable iff (rst)
        (!sel_left && !output_latency_select_left)
        |=> data_oe_left == 2'h0 || output_latency_select_left)
        else $error("left data not floated after deselect");

    deselect_right_a: assert property (@(posedge clock_right) disable iff (rst)
        (!sel_right && !output_latency_select_right)
        |=> data_oe_right == 2'h0 || output_latency_select_right)
        else $error("right data not floated after deselect");

    upper_lane_a: assert property (@(posedge clock_right) disable iff (rst)
        (req_right.upper_byte_sel_n && !output_latency_select_right)
        |=> !data_oe_right[1] || output_latency_select_right)
        else $error("upper lane driven while deselected");

    lower_lane_a: assert property (@(posedge clock_left) disable iff (rst)
        (req_left.lower_byte_sel_n && !output_latency_select_left)
        |=> !data_oe_left[0] || output_latency_select_left)
        else $error("left lower lane driven while deselected");

    upper_lane_left_a: assert property (@(posedge clock_left) disable iff (rst)
        (req_left.upper_byte_sel_n && !output_latency_select_left)
        |=> !data_oe_left[1] || output_latency_select_left)
        else $error("left upper lane driven while deselected");

    lower_lane_right_a: assert property (@(posedge clock_right) disable iff (rst)
        (req_right.lower_byte_sel_n && !output_latency_select_right)
        |=> !data_oe_right[0] || output_latency_select_right)
        else $error("right lower lane driven while deselected");

    read_both_left_a: assert property (@(posedge clock_left) disable iff (rst)
        (sel_left && req_left.read_write && !req_left.upper_byte_sel_n
            && !req_left.lower_byte_sel_n && !output_latency_select_left)
        |=> data_oe_left == 2'h3 || output_latency_select_left || output_enable_left_n)
        else $error("left read of both lanes did not drive both lanes");

    read_both_right_a: assert property (@(posedge clock_right) disable iff (rst)
        (sel_right && req_right.read_write && !req_right.upper_byte_sel_n
            && !req_right.lower_byte_sel_n && !output_latency_select_right)
        |=> data_oe_right == 2'h3 || output_latency_select_right || output_enable_right_n)
        else $error("right read of both lanes did not drive both lanes");

    // The output enable overrides everything without waiting for a clock.
    oe_gate_left_a: assert property (@(posedge clock_left) disable iff (rst)
        output_enable_left_n |-> data_oe_left == 2'h0)
        else $error("left pins driven with the output enable off");

    oe_gate_right_a: assert property (@(posedge clock_right) disable iff (rst)
        output_enable_right_n |-> data_oe_right == 2'h0)
        else $error("right pins driven with the output enable off");

    pipe_off_left_a: assert property (@(posedge clock_left) disable iff (rst)
        left_pipe_off_s |=> data_oe_left == 2'h0 || !output_latency_select_left)
        else $error("left pipelined pins not floated two edges after deselect");

    pipe_off_right_a: assert property (@(posedge clock_right) disable iff (rst)
        right_pipe_off_s |=> data_oe_right == 2'h0 || !output_latency_select_right)
        else $error("right pipelined pins not floated two edges after deselect");

    pipe_hold_left_a: assert property (@(posedge clock_left) disable iff (rst)
        left_pipe_last_s
        |=> data_oe_left[1] || output_enable_left_n || !output_latency_select_left)
        else $error("left pipelined read cut short by a deselect");

    pipe_upper_left_a: assert property (@(posedge clock_left) disable iff (rst)
        left_pipe_upper_off_s |=> !data_oe_left[1] || !output_latency_select_left)
        else $error("left pipelined upper lane driven while released");
endmodule

// >>> pkg/dpsr_defs.svh
// Constants for the dual-port synchronous static RAM port.
`ifndef DPSR_DEFS_SVH
`define DPSR_DEFS_SVH
`define DPSR_DATA_W 18
`define DPSR_BYTE_W 9
`define DPSR_DEPTH_BIG 8192
`define DPSR_ADDR_W_BIG 13
`define DPSR_DEPTH_SMALL 4096
`define DPSR_ADDR_W_SMALL 12
`define DPSR_ADDR_ZERO 13'h0000
`define DPSR_ADDR_ONE 13'h0001
`define DPSR_LAT_FLOW 1'h0
`define DPSR_LAT_PIPE 1'h1
`endif

// >>> pkg/dpsr_pkg.sv
// Types shared by the dual-port synchronous static RAM port.
`include "dpsr_defs.svh"
package dpsr_pkg;
    typedef struct packed {
        logic [`DPSR_ADDR_W_BIG-1:0] addr;
        logic [`DPSR_DATA_W-1:0] wdata;
        logic chip_select_low_n;
        logic chip_select_high;
        logic upper_byte_sel_n;
        logic lower_byte_sel_n;
        logic read_write;
        logic address_load_strobe_n;
        logic counter_advance_n;
        logic counter_clear_n;
    } dpsr_req_t;
    typedef struct packed {
        logic [`DPSR_DATA_W-1:0] rdata;
        logic [1:0] lane_oe;
    } dpsr_out_t;
endpackage

// >>> tb/dpsr_ctrl_model.sv
// Controller model that drives the request of one port.
`timescale 1ns/1ps
module dpsr_ctrl_model
    import dpsr_pkg::*;
(
    // Request to the port.
    output dpsr_req_t req
);
    initial begin
        req = '0;
    end
    // Callers change the request only just after a rising edge.
    // A cross-port read waits a whole cycle, longer than the write-to-read delay.
    task put(input dpsr_req_t r);
        req = r;
    endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for the dual-port synchronous static RAM.
`timescale 1ns/1ps
module tb;
    import dpsr_pkg::*;
    logic clock = 0;
    logic rst = 1;
    logic lat = 0;
    logic oen = 0;
    logic lat_r = 0;
    logic oen_r = 0;
    dpsr_req_t rl;
    dpsr_req_t rr;
    dpsr_req_t r;
    logic [17:0] dl;
    logic [17:0] dr;
    logic [1:0] el;
    logic [1:0] er;
    int fail_count = 0;
    int n_checks = 0;
    dpsr_ctrl_model dpsr_ctrl_model_i (.req(rl));
    dpsr_ctrl_model dpsr_ctrl_model_r_i (.req(rr));
    dpsr_top dpsr_top_i (.clock_left(clock), .clock_right(clock), .rst(rst),
        .req_left(rl), .output_latency_select_left(lat), .output_enable_left_n(oen),
        .data_out_left(dl), .data_oe_left(el), .req_right(rr),
        .output_latency_select_right(lat_r), .output_enable_right_n(oen_r),
        .data_out_right(dr), .data_oe_right(er));
    initial begin
        forever #25 clock = ~clock;
    end
    function automatic dpsr_req_t mk(logic [12:0] a, logic [17:0] d, logic rd, logic [1:0] l);
        return '{a, d, 1'h0, 1'h1, l[1], l[0], rd, 1'h0, 1'h1, 1'h1};
    endfunction
    function automatic dpsr_req_t idle();
        return '{13'h0000, 18'h00000, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1};
    endfunction
    task cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task check(input logic [19:0] s, input logic [19:0] e);
        n_checks++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [12:0] a, input logic [17:0] d);
        dpsr_ctrl_model_i.put(mk(a, d, 1'h0, 2'h0));
        cyc(1);
        dpsr_ctrl_model_i.put(idle());
        cyc(2);
    endtask
    task t_latency;
        wr(13'h0005, 18'h2a5a5);
        for (int i = 0; i < 2; i++) begin
            lat = i[0];
            lat_r = !i[0];
            dpsr_ctrl_model_i.put(mk(13'h0005, 18'h0, 1'h1, 2'h0));
            cyc(1);
            if (i == 1) begin
                check({18'h0, el}, 20'h0);
                cyc(1);
            end
            check({el, dl}, {2'h3, 18'h2a5a5});
            dpsr_ctrl_model_i.put(idle());
            cyc(2);
        end
        lat = 1'h0;
        lat_r = 1'h0;
        $display("test latency done");
    endtask
    task t_lanes;
        for (logic [1:0] i = 2'h1; i < 2'h3; i++) begin
            dpsr_ctrl_model_i.put(mk(13'h0005, 18'h0, 1'h1, i));
            cyc(1);
            check({18'h0, el}, {18'h0, ~i});
            dpsr_ctrl_model_i.put(idle());
            cyc(1);
        end
        $display("test lanes done");
    endtask
    task t_deselect;
        dpsr_ctrl_model_i.put(mk(13'h0005, 18'h0, 1'h1, 2'h0));
        cyc(2);
        check({el, dl}, {2'h3, 18'h2a5a5});
        oen = 1'h1;
        cyc(1);
        check({18'h0, el}, 20'h0);
        oen = 1'h0;
        #1;
        check({18'h0, el}, 20'h3);
        dpsr_ctrl_model_i.put(idle());
        cyc(1);
        check({18'h0, el}, 20'h0);
        lat = 1'h1;
        dpsr_ctrl_model_i.put(mk(13'h0005, 18'h0, 1'h1, 2'h0));
        cyc(2);
        check({el, dl}, {2'h3, 18'h2a5a5});
        dpsr_ctrl_model_i.put(idle());
        cyc(1);
        check({18'h0, el}, 20'h3);
        cyc(1);
        check({18'h0, el}, 20'h0);
        cyc(1);
        lat = 1'h0;
        $display("test deselect done");
    endtask
    task t_counter;
        wr(13'h0000, 18'h00011);
        wr(13'h0001, 18'h00022);
        r = mk(13'h0007, 18'h0, 1'h1, 2'h0);
        r.address_load_strobe_n = 1'h1;
        r.counter_clear_n = 1'h0;
        dpsr_ctrl_model_i.put(r);
        cyc(1);
        check({2'h0, dl}, {2'h0, 18'h00011});
        r.counter_clear_n = 1'h1;
        r.counter_advance_n = 1'h0;
        dpsr_ctrl_model_i.put(r);
        cyc(1);
        check({2'h0, dl}, {2'h0, 18'h00022});
        r.counter_advance_n = 1'h1;
        dpsr_ctrl_model_i.put(r);
        cyc(1);
        check({2'h0, dl}, {2'h0, 18'h00022});
        dpsr_ctrl_model_i.put(idle());
        cyc(2);
        $display("test counter done");
    endtask
    task t_cross;
        dpsr_ctrl_model_i.put(mk(13'h0009, 18'h3c3c3, 1'h0, 2'h0));
        cyc(1);
        dpsr_ctrl_model_i.put(idle());
        dpsr_ctrl_model_r_i.put(mk(13'h0009, 18'h0, 1'h1, 2'h0));
        cyc(1);
        check({er, dr}, {2'h3, 18'h3c3c3});
        oen_r = 1'h1;
        cyc(1);
        check({18'h0, er}, 20'h0);
        oen_r = 1'h0;
        dpsr_ctrl_model_r_i.put(idle());
        cyc(1);
        $display("test cross done");
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge clock);
        #1;
        rst = 0;
        cyc(1);
        t_latency();
        t_lanes();
        t_deselect();
        t_counter();
        t_cross();
        end_of_test();
    end
endmodule
